// ===== rscmb_pkg.sv
// package for the reset source combiner: register map, field positions,
// reset values and bus answer codes.
// assumes a 32-bit AXI4-Lite register bus with a 4-bit byte address.
package rscmb_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int STATUS_W = 16;
  localparam logic [3:0] STATUS_OFFSET = 4'h0;
  localparam logic [3:0] LIVE_OFFSET = 4'h4;

  // ************************************************************
  // reset_cause_status fields
  // ************************************************************
  localparam int BIT_POR = 0;
  localparam int BIT_BROWN = 1;
  localparam int BIT_IDLE = 2;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_WDOG_TIMEOUT = 4;
  localparam int BIT_WDOG_EN = 5;
  localparam int BIT_RESET_INSTR = 6;
  localparam int BIT_EXT_PIN = 7;
  localparam int BIT_VREG = 8;
  localparam int BIT_ILLOP = 14;
  localparam int BIT_TRAP = 15;
  localparam logic [15:0] STATUS_POR_VALUE = 16'h0001;
  localparam logic [15:0] STATUS_IMPL_MASK = 16'hC1FF;

  // ************************************************************
  // live source register fields
  // ************************************************************
  localparam int LIVE_WDT_EN = 0;
  localparam int LIVE_BROWN = 1;
  localparam int LIVE_EXTPIN = 2;
  localparam int LIVE_INTREQ = 3;

  // ************************************************************
  // pin synchroniser and bus answers
  // ************************************************************
  localparam int PIN_COUNT = 2;
  localparam int PIN_EXT_CLEAR = 0;
  localparam int PIN_BROWN = 1;
  localparam logic [1:0] PIN_IDLE = 2'h1;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rscmb_release_sync.sv
// reset release synchroniser: asserts at once, releases on the clock.
// assumes rawReset may come from pins or logic with no relation to clk.
`timescale 1ns/1ps
module rscmb_release_sync #(
  parameter int STAGES = rscmb_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rawReset,
  output logic syncReset
);

  logic [STAGES-1:0] chain_reg;

  // ************************************************************
  // async assert, clocked release
  // ************************************************************
  // release walks the chain so no flop sees a metastable edge
  always_ff @(posedge clk or posedge rawReset) begin
    if (rawReset) begin
      chain_reg <= '1;
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], 1'b0};
    end
  end

  assign syncReset = chain_reg[STAGES-1];

endmodule // rscmb_release_sync

// ===== rscmb_axil_slave.sv
// AXI4-Lite slave front end: takes address and data in either order,
// hands one write strobe and one read decode to the register file.
// assumes a single clock and that sys_rst is the only reset of the bus.
`timescale 1ns/1ps
module rscmb_axil_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [rscmb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rscmb_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rscmb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rscmb_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wrEn,
  output logic [rscmb_pkg::ADDR_W-1:0] wrAddr,
  output logic [rscmb_pkg::DATA_W-1:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic [rscmb_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [rscmb_pkg::DATA_W-1:0] rdData,
  input wire logic rdErr
);

  logic awHeld_reg;
  logic wHeld_reg;

  // ************************************************************
  // write channel
  // ************************************************************
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  assign wrEn = awHeld_reg && wHeld_reg && !s_axi_bvalid;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wrAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      wrAddr <= s_axi_awaddr;
    end else if (wrEn) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld_reg <= 1'b0;
      wrData <= '0;
      wrStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end else if (wrEn) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rscmb_pkg::RESP_OKAY;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrErr ? rscmb_pkg::RESP_SLVERR : rscmb_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  // decode is combinational on araddr, so the answer comes one cycle later
  assign s_axi_arready = !s_axi_rvalid;
  assign rdAddr = s_axi_araddr;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rscmb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdData;
      s_axi_rresp <= rdErr ? rscmb_pkg::RESP_SLVERR : rscmb_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rscmb_axil_slave

// ===== rscmb_reset_combiner.sv
// reset source combiner: merges every reset source into one master reset,
// records the cause in reset_cause_status and serves it over AXI4-Lite.
// assumes sys_rst is the power-on reset; pin sources are asynchronous,
// instruction and trap sources are one-cycle pulses on clk.
`timescale 1ns/1ps
module rscmb_reset_combiner (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic brownOutReq,
  input wire logic externalClearPinN,
  input wire logic resetInstr,
  input wire logic watchdogTimeout,
  input wire logic trapConflict,
  input wire logic illegalOp,
  input wire logic powerSaveInstr,
  input wire logic powerSaveSleep,
  input wire logic watchdogFuseEnable,
  output logic masterSystemReset,
  output logic watchdogEnabled,
  output logic regulatorSleepActive,
  input wire logic [rscmb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rscmb_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rscmb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rscmb_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [rscmb_pkg::PIN_COUNT-1:0] pinSync1_reg;
  logic [rscmb_pkg::PIN_COUNT-1:0] pinSync2_reg;
  logic extPinActive;
  logic brownActive;
  logic wdtFire;
  logic internalReq_reg;
  logic internalReq_next;
  logic rawReset;
  logic [rscmb_pkg::STATUS_W-1:0] status_reg;
  logic [rscmb_pkg::STATUS_W-1:0] status_next;
  logic [rscmb_pkg::STATUS_W-1:0] setMask;
  logic [rscmb_pkg::STATUS_W-1:0] clrMask;
  logic [rscmb_pkg::STATUS_W-1:0] writeMerged;
  logic statusWrite;
  logic wrEn;
  logic [rscmb_pkg::ADDR_W-1:0] wrAddr;
  logic [rscmb_pkg::DATA_W-1:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic [rscmb_pkg::ADDR_W-1:0] rdAddr;
  logic [rscmb_pkg::DATA_W-1:0] rdData;
  logic rdErr;
  logic [rscmb_pkg::DATA_W-1:0] liveWord;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic rscmbHit(
    input logic [rscmb_pkg::ADDR_W-1:0] addr,
    input logic [rscmb_pkg::ADDR_W-1:0] offset
  );
    // low two bits ignored: every register is one aligned word
    rscmbHit = (addr[rscmb_pkg::ADDR_W-1:2] == offset[rscmb_pkg::ADDR_W-1:2]);
  endfunction

  function automatic logic [15:0] rscmbMerge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] strb
  );
    logic [15:0] result;
    result = old;
    if (strb[0]) begin
      result[7:0] = data[7:0];
    end
    if (strb[1]) begin
      result[15:8] = data[15:8];
    end
    rscmbMerge = result;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinSync1_reg <= rscmb_pkg::PIN_IDLE;
      pinSync2_reg <= rscmb_pkg::PIN_IDLE;
    end else begin
      pinSync1_reg <= {brownOutReq, externalClearPinN};
      pinSync2_reg <= pinSync1_reg;
    end
  end

  assign extPinActive = !pinSync2_reg[rscmb_pkg::PIN_EXT_CLEAR];
  assign brownActive = pinSync2_reg[rscmb_pkg::PIN_BROWN];

  // ************************************************************
  // reset merge
  // ************************************************************
  // watchdog time-outs only count while the watchdog is enabled
  assign watchdogEnabled = status_reg[rscmb_pkg::BIT_WDOG_EN] || watchdogFuseEnable;
  assign wdtFire = watchdogTimeout && watchdogEnabled;
  assign internalReq_next = resetInstr || wdtFire || trapConflict || illegalOp;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      internalReq_reg <= 1'b0;
    end else begin
      internalReq_reg <= internalReq_next;
    end
  end

  // raw pins feed only this async assert path; flag logic uses the synced copies
  assign rawReset = sys_rst || brownOutReq || !externalClearPinN || internalReq_reg;

  rscmb_release_sync #(
    .STAGES(rscmb_pkg::SYNC_STAGES)
  ) releaseSync (
    .clk(clk),
    .rawReset(rawReset),
    .syncReset(masterSystemReset)
  );

  // ************************************************************
  // reset cause status
  // ************************************************************
  always_comb begin
    setMask = '0;
    setMask[rscmb_pkg::BIT_BROWN] = brownActive;
    setMask[rscmb_pkg::BIT_EXT_PIN] = extPinActive;
    setMask[rscmb_pkg::BIT_RESET_INSTR] = resetInstr;
    setMask[rscmb_pkg::BIT_WDOG_TIMEOUT] = wdtFire;
    setMask[rscmb_pkg::BIT_SLEEP] = powerSaveInstr && powerSaveSleep;
    setMask[rscmb_pkg::BIT_IDLE] = powerSaveInstr && !powerSaveSleep;
    setMask[rscmb_pkg::BIT_TRAP] = trapConflict;
    setMask[rscmb_pkg::BIT_ILLOP] = illegalOp;
  end

  always_comb begin
    clrMask = '0;
    // brown-out clears every cause flag but the pin flags and the power-on flag
    clrMask[rscmb_pkg::BIT_TRAP] = brownActive;
    clrMask[rscmb_pkg::BIT_ILLOP] = brownActive;
    clrMask[rscmb_pkg::BIT_RESET_INSTR] = brownActive;
    clrMask[rscmb_pkg::BIT_SLEEP] = brownActive;
    clrMask[rscmb_pkg::BIT_IDLE] = brownActive;
    clrMask[rscmb_pkg::BIT_WDOG_TIMEOUT] = brownActive || powerSaveInstr;
  end

  assign statusWrite = wrEn && rscmbHit(wrAddr, rscmb_pkg::STATUS_OFFSET);

  always_comb begin
    writeMerged = status_reg;
    if (statusWrite) begin
      writeMerged = rscmbMerge(status_reg, wrData[15:0], wrStrb[1:0]);
    end
    // hardware sets win over software and hardware clears in the same cycle
    status_next = ((writeMerged & ~clrMask) | setMask) & rscmb_pkg::STATUS_IMPL_MASK;
  end

  // only power-on resets this register; master reset leaves it alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= rscmb_pkg::STATUS_POR_VALUE;
    end else begin
      status_reg <= status_next;
    end
  end

  assign regulatorSleepActive = status_reg[rscmb_pkg::BIT_VREG];

  // ************************************************************
  // register access
  // ************************************************************
  always_comb begin
    liveWord = '0;
    liveWord[rscmb_pkg::LIVE_WDT_EN] = watchdogEnabled;
    liveWord[rscmb_pkg::LIVE_BROWN] = brownActive;
    liveWord[rscmb_pkg::LIVE_EXTPIN] = extPinActive;
    liveWord[rscmb_pkg::LIVE_INTREQ] = internalReq_reg;
  end

  always_comb begin
    rdData = '0;
    rdErr = 1'b0;
    if (rscmbHit(rdAddr, rscmb_pkg::STATUS_OFFSET)) begin
      rdData[15:0] = status_reg;
    end else if (rscmbHit(rdAddr, rscmb_pkg::LIVE_OFFSET)) begin
      rdData = liveWord;
    end else begin
      rdErr = 1'b1;
    end
  end

  // live register is read-only: writes there are dropped with OKAY
  assign wrErr = !rscmbHit(wrAddr, rscmb_pkg::STATUS_OFFSET)
    && !rscmbHit(wrAddr, rscmb_pkg::LIVE_OFFSET);

  rscmb_axil_slave axilSlave (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  a_merge_pulse:
    assert property (@(posedge clk) disable iff (sys_rst)
      (resetInstr || trapConflict || illegalOp) |=> masterSystemReset)
    else $error("reset source pulse did not raise master reset");

  a_hold_active:
    assert property (@(posedge clk) disable iff (sys_rst)
      internalReq_reg |-> masterSystemReset)
    else $error("master reset low while a source is active");

  a_sync_release:
    assert property (@(posedge clk) disable iff (sys_rst)
      $fell(masterSystemReset) |-> !$past(internalReq_reg) && !$past(internalReq_reg, 2))
    else $error("master reset released too soon after a source");

  a_por_value:
    assert property (@(posedge clk)
      $fell(sys_rst) |-> status_reg == rscmb_pkg::STATUS_POR_VALUE)
    else $error("status not at power-on value after power-on");

  a_trap_flag:
    assert property (@(posedge clk) disable iff (sys_rst)
      trapConflict |=> status_reg[rscmb_pkg::BIT_TRAP])
    else $error("trap conflict flag not set");

  a_illop_flag:
    assert property (@(posedge clk) disable iff (sys_rst)
      illegalOp |=> status_reg[rscmb_pkg::BIT_ILLOP])
    else $error("illegal op flag not set");

  a_unimpl_zero:
    assert property (@(posedge clk) disable iff (sys_rst)
      s_axi_rvalid |-> s_axi_rdata[13:9] == 5'h00)
    else $error("unimplemented status bits read nonzero");

  a_extpin_flag:
    assert property (@(posedge clk) disable iff (sys_rst)
      !externalClearPinN [*3] |=> status_reg[rscmb_pkg::BIT_EXT_PIN])
    else $error("external pin flag not set after pin reset");

  a_swr_flag:
    assert property (@(posedge clk) disable iff (sys_rst)
      resetInstr |=> status_reg[rscmb_pkg::BIT_RESET_INSTR] && masterSystemReset)
    else $error("reset instruction not recorded");

  a_wdt_fuse:
    assert property (@(posedge clk) disable iff (sys_rst)
      watchdogFuseEnable && watchdogTimeout |=> status_reg[rscmb_pkg::BIT_WDOG_TIMEOUT])
    else $error("fuse-enabled watchdog time-out ignored");

  a_wdt_gate:
    assert property (@(posedge clk) disable iff (sys_rst)
      watchdogTimeout && !watchdogEnabled && !resetInstr && !trapConflict && !illegalOp
      |=> !internalReq_reg)
    else $error("disabled watchdog caused a reset");

  a_watchdog_timeout_flag_clear:
    assert property (@(posedge clk) disable iff (sys_rst)
      powerSaveInstr && !wdtFire |=> !status_reg[rscmb_pkg::BIT_WDOG_TIMEOUT])
    else $error("power-save did not clear watchdog flag");

  a_sleep_idle:
    assert property (@(posedge clk) disable iff (sys_rst)
      powerSaveInstr && !brownActive
      |=> ($past(powerSaveSleep) ? status_reg[rscmb_pkg::BIT_SLEEP]
      : status_reg[rscmb_pkg::BIT_IDLE]))
    else $error("sleep or idle flag not set by power-save");

  a_brown_flag:
    assert property (@(posedge clk) disable iff (sys_rst)
      brownActive |=> status_reg[rscmb_pkg::BIT_BROWN])
    else $error("brown-out not recorded");

  // the raw pin holds the master reset; the synced copy lags its release
  a_brown_hold:
    assert property (@(posedge clk) disable iff (sys_rst)
      brownOutReq |=> masterSystemReset)
    else $error("master reset low during brown-out");

  a_write_store:
    assert property (@(posedge clk) disable iff (sys_rst)
      statusWrite && wrStrb[1:0] == 2'h3 && setMask == 16'h0000 && clrMask == 16'h0000
      |=> status_reg == (($past(wrData[15:0])) & rscmb_pkg::STATUS_IMPL_MASK))
    else $error("status write not stored");

  a_write_noreset:
    assert property (@(posedge clk) disable iff (sys_rst)
      statusWrite && !internalReq_next |=> !internalReq_reg)
    else $error("software write caused a reset request");

endmodule // rscmb_reset_combiner

// ===== reset_source_combiner_tb_top.sv
// testbench for the reset source combiner: register tests over AXI4-Lite
// and one scenario per reset source, checked against the status register.
// assumes rscmb_pkg and the design files are compiled before this file.
`timescale 1ns/1ps
module reset_source_combiner_tb_top;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk, sys_rst, brownOutReq, externalClearPinN, powerSaveSleep, watchdogFuseEnable;
  logic [4:0] pulseVec; // instr, trap, illegal op, watchdog, power-save
  logic masterSystemReset, watchdogEnabled, regulatorSleepActive;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rd;
  int nErrors, testsRun;
  int srcBit[4] = '{rscmb_pkg::BIT_RESET_INSTR, rscmb_pkg::BIT_TRAP, rscmb_pkg::BIT_ILLOP,
                    rscmb_pkg::BIT_WDOG_TIMEOUT};

  rscmb_reset_combiner uut (.clk(clk), .sys_rst(sys_rst), .brownOutReq(brownOutReq),
    .externalClearPinN(externalClearPinN), .resetInstr(pulseVec[0]),
    .watchdogTimeout(pulseVec[3]), .trapConflict(pulseVec[1]), .illegalOp(pulseVec[2]),
    .powerSaveInstr(pulseVec[4]), .powerSaveSleep(powerSaveSleep),
    .watchdogFuseEnable(watchdogFuseEnable), .masterSystemReset(masterSystemReset),
    .watchdogEnabled(watchdogEnabled), .regulatorSleepActive(regulatorSleepActive),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ************************************************************
  // bus tasks: handshakes and answers taken at the rising edge,
  // before that edge's own updates land
  // ************************************************************
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ta && tw));
    do begin
      @(posedge clk);
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [31:0] exp);
    axr(rscmb_pkg::STATUS_OFFSET, rd, resp);
    check(rd, exp);
    check(resp, rscmb_pkg::RESP_OKAY);
  endtask

  task automatic wrSt(input logic [31:0] d);
    axw(rscmb_pkg::STATUS_OFFSET, d, resp);
    check(resp, rscmb_pkg::RESP_OKAY);
  endtask

  // one-cycle pulse; master reset is looked at in the cycle after it is taken
  task automatic pulse(input int i);
    @(posedge clk);
    pulseVec[i] <= 1'b1;
    @(posedge clk);
    pulseVec <= 5'h00;
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  task automatic endTest(input string name);
    $display("test %s done, mismatches so far %0d", name, nErrors);
  endtask

  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // watchdog: whole run is under two hundred cycles, limit is far above it
  // ************************************************************
  initial begin
    #100us;
    nErrors++;
    $display("unexpected at %0t: run did not finish", $time);
    stopTest();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    sys_rst = 1'b1;
    brownOutReq = 1'b0;
    externalClearPinN = 1'b1;
    powerSaveSleep = 1'b0;
    watchdogFuseEnable = 1'b0;
    pulseVec = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (20) @(posedge clk);
    check(masterSystemReset, 1'b1);
    sys_rst <= 1'b0;
    settle();
    check(masterSystemReset, 1'b0);
    rdChk(rscmb_pkg::STATUS_POR_VALUE);
    endTest("power on");
    wrSt(32'h0000FFFF);
    rdChk(32'h0000C1FF);
    check(masterSystemReset, 1'b0);
    check(regulatorSleepActive, 1'b1);
    check(watchdogEnabled, 1'b1);
    wrSt(32'h00000000);
    rdChk(32'h0);
    check({regulatorSleepActive, watchdogEnabled}, 2'b00);
    pulse(3);
    settle();
    rdChk(32'h0);
    watchdogFuseEnable <= 1'b1;
    @(posedge clk);
    check(watchdogEnabled, 1'b1);
    axr(rscmb_pkg::LIVE_OFFSET, rd, resp);
    check(rd, 32'h1 << rscmb_pkg::LIVE_WDT_EN);
    axr(4'h8, rd, resp);
    check(rd, 32'h0);
    check(resp, rscmb_pkg::RESP_SLVERR);
    endTest("register access");
    for (int i = 0; i < 4; i++) begin
      wrSt(32'h0);
      pulse(i);
      @(negedge clk);
      check(masterSystemReset, 1'b1);
      settle();
      check(masterSystemReset, 1'b0);
      rdChk(32'h1 << srcBit[i]);
    end
    endTest("internal sources");
    wrSt(32'h1 << rscmb_pkg::BIT_WDOG_TIMEOUT);
    powerSaveSleep <= 1'b1;
    pulse(4);
    settle();
    rdChk(32'h1 << rscmb_pkg::BIT_SLEEP);
    powerSaveSleep <= 1'b0;
    pulse(4);
    settle();
    rdChk(32'h0000000C);
    endTest("power save");
    externalClearPinN <= 1'b0;
    @(negedge clk);
    check(masterSystemReset, 1'b1);
    repeat (4) @(posedge clk);
    externalClearPinN <= 1'b1;
    settle();
    rdChk(32'h0000008C);
    wrSt(32'h0000C0DC);
    check(masterSystemReset, 1'b0);
    brownOutReq <= 1'b1;
    repeat (5) @(posedge clk);
    brownOutReq <= 1'b0;
    settle();
    rdChk(32'h00000082);
    endTest("pin sources");
    wrSt(32'h00000120);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    check(masterSystemReset, 1'b1);
    sys_rst <= 1'b0;
    settle();
    rdChk(rscmb_pkg::STATUS_POR_VALUE);
    endTest("second power on");
    stopTest();
  end
endmodule // reset_source_combiner_tb_top
